// ---- rti_pkg.sv ----
// Purpose: Shared constants and types for the terminal command interpreter.
// Assumes: 100 MHz aclk, AXI4-Lite register access, 8N1 serial link.
// Notes:   Long timer counts are defaults for top-level parameters.
package rti_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_FAST = 2400;
   localparam int BAUD_SLOW = 1200;
   localparam int CNT_W = 17;
   localparam logic [CNT_W-1:0] BIT_CYC_FAST = CNT_W'(CLK_HZ / BAUD_FAST);
   localparam logic [CNT_W-1:0] BIT_CYC_SLOW = CNT_W'(CLK_HZ / BAUD_SLOW);
   localparam int TMR_W = 36;
   localparam int RELOCK_MIN = 5;
   localparam logic [TMR_W-1:0] RELOCK_CYC = TMR_W'(64'(RELOCK_MIN) * 64'd60 * 64'(CLK_HZ));
   localparam int RESTORE_S = 5;
   localparam logic [TMR_W-1:0] RESTORE_CYC = TMR_W'(64'(RESTORE_S) * 64'(CLK_HZ));

   // ----------------------------------------
   // Register map (byte addresses) and reset values
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EVENTS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_RXDATA = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PWD_LO = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PWD_HI = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h1c;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PWD_RST = 32'h0000_0000;
   localparam logic [47:0] FACTORY_PW = 48'h4141_4141_4141;
   localparam logic LOAD_RST = 1'b1;
   localparam logic [1:0] COLOUR_RST = 2'h0;
   // Pins: rxd idles high, the rest low
   localparam logic [3:0] PIN_RST = 4'h1;
   localparam int PIN_RXD = 0;
   localparam int PIN_ALARM = 1;
   localparam int PIN_POS4 = 2;
   localparam int PIN_MODEM = 3;
   // CMD register bit positions
   localparam int CMD_PW_COMMIT = 0;
   localparam int CMD_PW_TRY = 1;
   localparam int CMD_LOAD_REQ = 2;
   localparam int CMD_LOAD_ON = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Keystrokes
   // ----------------------------------------
   localparam logic [7:0] KEY_SPACE = 8'h20;
   localparam logic [7:0] KEY_UP = 8'h55;
   localparam logic [7:0] KEY_DOWN = 8'h44;
   localparam logic [7:0] KEY_ENTER = 8'h0d;
   localparam logic [7:0] KEY_REDRAW = 8'h52;
   localparam logic [7:0] KEY_CHARSET = 8'h43;
   localparam logic [7:0] KEY_COLOUR = 8'h4f;
   localparam logic [7:0] KEY_SCRNUM = 8'h53;
   localparam logic [7:0] KEY_SILENCE = 8'h41;
   localparam logic [7:0] KEY_BINARY = 8'h45;
   localparam logic [7:0] KEY_HANGUP = 8'h47;
   localparam logic [7:0] KEY_CHORD_UDS = 8'h37;
   localparam logic [7:0] KEY_CHORD_UD = 8'h4b;
   localparam logic [7:0] KEY_CHORD_DS = 8'h5a;
   localparam logic [31:0] EXIT_WORD = 32'h4558_4954;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      RTI_MD_IDLE = 2'b00,
      RTI_MD_PANEL = 2'b01,
      RTI_MD_BINARY = 2'b10
   } rti_mode_t;

   typedef struct packed {
      logic load_refused;
      logic english;
      logic hangup;
      logic bin_exit;
      logic bin_enter;
      logic silence;
      logic scr_num;
      logic colour;
      logic charset;
      logic redraw;
      logic alarm_rpt;
      logic full_draw;
      logic enter;
      logic down;
      logic up;
   } rti_evt_t;

   typedef struct packed {
      logic modem;
      logic pos4;
      logic rx_busy;
      logic tx_busy;
      logic restore_pend;
      logic load_on;
      logic timed;
      logic locked;
      logic [1:0] colour;
      logic charset;
      rti_mode_t mode;
   } rti_stat_t;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } rti_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } rti_axi_rsp_t;

endpackage

// ---- rti_top.sv ----
// Purpose: Keystroke interpreter, serial link and load lock for the terminal port.
// Assumes: aclk 100 MHz, synchronous active-low aresetn, pins asynchronous.
// Notes:   Screen drawing lives elsewhere; this block only issues event pulses.
// Operation
// - Space enters remote panel mode and requests a full panel image.
// - A new alarm requests an unsolicited alarm report.
// - Up, down and enter keys act as the panel buttons in panel mode.
// - Key R requests a full screen redraw.
// - Key C switches glyph encoding to the extended PC character set.
// - Key O steps through four colour schemes and redraws.
// - Key S shows the current screen index on the top line.
// - Key A mutes the local alarm and the terminal speaker.
// - Key E enters binary protocol; the text EXIT returns to panel mode.
// - Key G hangs up while a modem session is active.
// - Keys 7, K and Z emulate the three button chords.
// - The up, down and silence chord returns the language to English.
// - In switch position 4 a load request to the opposite state switches it.
// - A load-on command restores the load five seconds later.
// - While locked, password-less edits and load switching are refused.
// - Starts unlocked; committing a non-factory password edit locks load control.
// - Passwords are one to six characters, factory value AAAAAA.
// - Entering the matching password unlocks load control.
// - Unlock lasts five minutes, then relocks by itself.
// - While unlocked, a committed edit stores the new password.
// - Setting the factory password leaves control unlocked without limit.
// - Link runs at 2400 or 1200 bit/s as the device setting selects.
// - Each character is eight data bits, no parity, one stop bit.
module rti_top
   import rti_pkg::*;
#(
   parameter logic [CNT_W-1:0] BIT_FAST = BIT_CYC_FAST,
   parameter logic [CNT_W-1:0] BIT_SLOW = BIT_CYC_SLOW,
   parameter logic [TMR_W-1:0] RELOCK_CNT = RELOCK_CYC,
   parameter logic [TMR_W-1:0] RESTORE_CNT = RESTORE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire rti_axi_req_t axi_req,
   output rti_axi_rsp_t axi_rsp,
   input wire logic rxd,
   output logic txd,
   input wire logic alarm_in,
   input wire logic pos4_in,
   input wire logic modem_session,
   output rti_evt_t evt,
   output logic load_on
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= OFS_CMD);
   endfunction

   // Letters are matched in either case
   function automatic logic [7:0] upcase(input logic [7:0] c);
      return (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
   // Three stages; a change is taken once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_r <= PIN_RST;
         pin_s2_r <= PIN_RST;
         pin_s3_r <= PIN_RST;
         pin_r <= PIN_RST;
      end else begin
         pin_s1_r <= {modem_session, pos4_in, alarm_in, rxd};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         pin_r <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r ^ pin_s3_r));
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r, rdata_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   logic aw_hs, w_hs, wr_go;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [31:0] rd_mux;

   assign axi_rsp.awready = !aw_got_r && !bvalid_r;
   assign axi_rsp.wready = !w_got_r && !bvalid_r;
   assign axi_rsp.arready = !rvalid_r;
   assign axi_rsp.bvalid = bvalid_r;
   assign axi_rsp.bresp = bresp_r;
   assign axi_rsp.rvalid = rvalid_r;
   assign axi_rsp.rdata = rdata_r;
   assign axi_rsp.rresp = rresp_r;
   assign aw_hs = axi_req.awvalid && axi_rsp.awready;
   assign w_hs = axi_req.wvalid && axi_rsp.wready;
   // Address and data may arrive in either order
   assign wr_go = (aw_got_r || aw_hs) && (w_got_r || w_hs);
   assign wr_addr = aw_got_r ? aw_addr_r : axi_req.awaddr;
   assign wr_data = w_got_r ? w_data_r : axi_req.wdata;
   assign wr_strb = w_got_r ? w_strb_r : axi_req.wstrb;

   // Write channel holding and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         bvalid_r <= 1'b1;
         bresp_r <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else begin
         if (aw_hs) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= axi_req.awaddr;
         end
         if (w_hs) begin
            w_got_r <= 1'b1;
            w_data_r <= axi_req.wdata;
            w_strb_r <= axi_req.wstrb;
         end
         if (bvalid_r && axi_req.bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel; data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (axi_req.arvalid && axi_rsp.arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && axi_req.rready) begin
         rvalid_r <= 1'b0;
      end
   end

   logic wr_ctrl, wr_events, wr_tx, wr_pwlo, wr_pwhi, wr_cmd;
   logic [31:0] cmd_w;
   assign wr_ctrl = wr_go && wr_addr == OFS_CTRL;
   assign wr_events = wr_go && wr_addr == OFS_EVENTS;
   assign wr_tx = wr_go && wr_addr == OFS_TXDATA && wr_strb[0];
   assign wr_pwlo = wr_go && wr_addr == OFS_PWD_LO;
   assign wr_pwhi = wr_go && wr_addr == OFS_PWD_HI;
   assign wr_cmd = wr_go && wr_addr == OFS_CMD;
   assign cmd_w = wr_cmd ? merge(32'h0, wr_data, wr_strb) : 32'h0;

   // Software registers
   logic [31:0] ctrl_r, pwlo_r, pwhi_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         pwlo_r <= PWD_RST;
         pwhi_r <= PWD_RST;
      end else begin
         if (wr_ctrl) ctrl_r <= merge(ctrl_r, wr_data, wr_strb) & 32'h1;
         if (wr_pwlo) pwlo_r <= merge(pwlo_r, wr_data, wr_strb);
         if (wr_pwhi) pwhi_r <= merge(pwhi_r, wr_data, wr_strb) & 32'hffff;
      end
   end

   // ----------------------------------------
   // Serial receiver and transmitter
   // ----------------------------------------
   logic [CNT_W-1:0] bit_len;
   assign bit_len = ctrl_r[0] ? BIT_SLOW : BIT_FAST;

   logic rx_busy_r, rx_valid_r;
   logic [CNT_W-1:0] rx_cnt_r;
   logic [3:0] rx_bit_r;
   logic [7:0] rx_sh_r, rx_byte_r;
   // Start at the falling edge, sample mid-bit, keep only frames with a stop bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_busy_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r <= '0;
         rx_byte_r <= '0;
      end else begin
         rx_valid_r <= 1'b0;
         if (!rx_busy_r) begin
            if (!pin_r[PIN_RXD]) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r <= bit_len >> 1;
               rx_bit_r <= '0;
            end
         end else if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
         end else if (rx_bit_r == 4'd0 && pin_r[PIN_RXD]) begin
            rx_busy_r <= 1'b0; // Glitch, not a start bit
         end else if (rx_bit_r < 4'd9) begin
            if (rx_bit_r != 4'd0) rx_sh_r <= {pin_r[PIN_RXD], rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 1'b1;
            rx_cnt_r <= bit_len - 1'b1;
         end else begin
            rx_busy_r <= 1'b0;
            if (pin_r[PIN_RXD]) begin
               rx_valid_r <= 1'b1;
               rx_byte_r <= rx_sh_r;
            end
         end
      end
   end

   logic tx_busy_r;
   logic [CNT_W-1:0] tx_cnt_r;
   logic [3:0] tx_bit_r;
   logic [9:0] tx_sh_r;
   // Start bit, eight data bits LSB first, one stop bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         tx_sh_r <= '1;
         txd <= 1'b1;
      end else if (!tx_busy_r) begin
         txd <= 1'b1;
         if (wr_tx) begin
            tx_busy_r <= 1'b1;
            tx_sh_r <= {1'b1, wr_data[7:0], 1'b0};
            tx_bit_r <= '0;
            tx_cnt_r <= '0;
         end
      end else if (tx_cnt_r != '0) begin
         tx_cnt_r <= tx_cnt_r - 1'b1;
      end else if (tx_bit_r == 4'd10) begin
         tx_busy_r <= 1'b0;
      end else begin
         txd <= tx_sh_r[0];
         tx_sh_r <= {1'b1, tx_sh_r[9:1]};
         tx_bit_r <= tx_bit_r + 1'b1;
         tx_cnt_r <= bit_len - 1'b1;
      end
   end

   // ----------------------------------------
   // Keystroke interpreter
   // ----------------------------------------
   rti_mode_t mode_r, mode_nxt;
   logic [1:0] exit_idx_r, exit_idx_nxt;
   logic alarm_d_r;
   logic [7:0] key;
   rti_evt_t evt_nxt;
   logic load_refused;
   assign key = upcase(rx_byte_r);

   // Decode one received byte into panel and menu events
   always_comb begin
      evt_nxt = '0;
      mode_nxt = mode_r;
      exit_idx_nxt = exit_idx_r;
      evt_nxt.alarm_rpt = pin_r[PIN_ALARM] && !alarm_d_r;
      evt_nxt.load_refused = load_refused;
      if (rx_valid_r) begin
         if (mode_r == RTI_MD_BINARY) begin
            // Only the EXIT word is watched here
            if (key == EXIT_WORD[31 - 8*exit_idx_r -: 8]) begin
               exit_idx_nxt = exit_idx_r + 1'b1;
               if (exit_idx_r == 2'd3) begin
                  mode_nxt = RTI_MD_PANEL;
                  evt_nxt.bin_exit = 1'b1;
                  exit_idx_nxt = 2'd0;
               end
            end else begin
               exit_idx_nxt = (key == EXIT_WORD[31:24]) ? 2'd1 : 2'd0;
            end
         end else if (key == KEY_SPACE) begin
            mode_nxt = RTI_MD_PANEL;
            evt_nxt.full_draw = 1'b1;
         end else if (mode_r == RTI_MD_PANEL) begin
            case (key)
               KEY_UP: evt_nxt.up = 1'b1;
               KEY_DOWN: evt_nxt.down = 1'b1;
               KEY_ENTER: evt_nxt.enter = 1'b1;
               KEY_REDRAW: evt_nxt.redraw = 1'b1;
               KEY_CHARSET: evt_nxt.charset = 1'b1;
               KEY_COLOUR: begin
                  evt_nxt.colour = 1'b1;
                  evt_nxt.redraw = 1'b1;
               end
               KEY_SCRNUM: evt_nxt.scr_num = 1'b1;
               KEY_SILENCE: evt_nxt.silence = 1'b1;
               KEY_BINARY: begin
                  mode_nxt = RTI_MD_BINARY;
                  evt_nxt.bin_enter = 1'b1;
                  exit_idx_nxt = 2'd0;
               end
               KEY_HANGUP: evt_nxt.hangup = pin_r[PIN_MODEM];
               KEY_CHORD_UDS: begin
                  evt_nxt.up = 1'b1;
                  evt_nxt.down = 1'b1;
                  evt_nxt.silence = 1'b1;
                  evt_nxt.english = 1'b1;
               end
               KEY_CHORD_UD: begin
                  evt_nxt.up = 1'b1;
                  evt_nxt.down = 1'b1;
               end
               KEY_CHORD_DS: begin
                  evt_nxt.down = 1'b1;
                  evt_nxt.silence = 1'b1;
               end
               default: evt_nxt.up = 1'b0;
            endcase
         end
      end
   end

   // Mode, alarm edge and event pulse registers
   logic charset_r;
   logic [1:0] colour_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= RTI_MD_IDLE;
         exit_idx_r <= 2'd0;
         alarm_d_r <= 1'b0;
         evt <= '0;
         charset_r <= 1'b0;
         colour_r <= COLOUR_RST;
      end else begin
         mode_r <= mode_nxt;
         exit_idx_r <= exit_idx_nxt;
         alarm_d_r <= pin_r[PIN_ALARM];
         evt <= evt_nxt;
         if (evt_nxt.charset) charset_r <= 1'b1;
         if (evt_nxt.colour) colour_r <= colour_r + 1'b1;
      end
   end

   // Sticky copy for software; a new event beats a same-cycle clear
   logic [14:0] events_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         events_r <= '0;
      end else begin
         events_r <= (events_r & ~15'(wr_events ? merge(32'h0, wr_data, wr_strb)
                     : 32'h0)) | 15'(evt_nxt);
      end
   end

   // ----------------------------------------
   // Password lock and load control
   // ----------------------------------------
   logic [47:0] pw_r, cand;
   logic locked_r, timed_r, restore_r;
   logic [TMR_W-1:0] relock_cnt_r, restore_cnt_r;
   logic pos4;
   assign cand = {pwhi_r[15:0], pwlo_r};
   assign pos4 = pin_r[PIN_POS4];
   // Requests to the present state, outside position 4, or while locked
   assign load_refused = cmd_w[CMD_LOAD_REQ] && (locked_r || !pos4 ||
                         cmd_w[CMD_LOAD_ON] == (load_on || restore_r));

   // Lock state and relock timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pw_r <= FACTORY_PW;
         locked_r <= 1'b0;
         timed_r <= 1'b0;
         relock_cnt_r <= '0;
      end else if (cmd_w[CMD_PW_COMMIT] && !locked_r && cand[7:0] != 8'h00) begin
         pw_r <= cand;
         if (cand == FACTORY_PW) begin
            timed_r <= 1'b0;
         end else begin
            locked_r <= 1'b1;
            timed_r <= 1'b0;
         end
      end else if (cmd_w[CMD_PW_TRY] && locked_r && cand == pw_r) begin
         locked_r <= 1'b0;
         timed_r <= 1'b1;
         relock_cnt_r <= RELOCK_CNT - 1'b1;
      end else if (!locked_r && timed_r) begin
         if (relock_cnt_r == '0) begin
            locked_r <= 1'b1;
            timed_r <= 1'b0;
         end else begin
            relock_cnt_r <= relock_cnt_r - 1'b1;
         end
      end
   end

   // Load switching; turn-on waits out the restart delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_on <= LOAD_RST;
         restore_r <= 1'b0;
         restore_cnt_r <= '0;
      end else if (cmd_w[CMD_LOAD_REQ] && !load_refused) begin
         if (cmd_w[CMD_LOAD_ON]) begin
            restore_r <= 1'b1;
            restore_cnt_r <= RESTORE_CNT - 1'b1;
         end else begin
            load_on <= 1'b0;
         end
      end else if (restore_r) begin
         if (restore_cnt_r == '0) begin
            load_on <= 1'b1;
            restore_r <= 1'b0;
         end else begin
            restore_cnt_r <= restore_cnt_r - 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   rti_stat_t stat;
   assign stat = '{modem: pin_r[PIN_MODEM], pos4: pos4, rx_busy: rx_busy_r, tx_busy: tx_busy_r,
                   restore_pend: restore_r, load_on: load_on, timed: timed_r, locked: locked_r,
                   colour: colour_r, charset: charset_r, mode: mode_r};
   // Password readback is hidden; software sees only the entry buffer
   always_comb begin
      case (axi_req.araddr)
         OFS_CTRL: rd_mux = ctrl_r;
         OFS_STATUS: rd_mux = 32'(stat);
         OFS_EVENTS: rd_mux = 32'(events_r);
         OFS_RXDATA: rd_mux = {23'h0, rx_valid_r, rx_byte_r};
         OFS_PWD_LO: rd_mux = pwlo_r;
         OFS_PWD_HI: rd_mux = pwhi_r;
         default: rd_mux = 32'h0;
      endcase
   end

endmodule

// ---- rti_props.sv ----
// Purpose: Port assertions for the interpreter.
// Assumes: Sees rti_top ports only.
// Notes:   Bound at the foot of this file.
module rti_props
   import rti_pkg::*;
(
   input logic aclk,
   input logic aresetn,
   input rti_axi_req_t axi_req,
   input rti_axi_rsp_t axi_rsp,
   input logic alarm_in,
   input logic txd,
   input rti_evt_t evt,
   input logic load_on
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> txd && evt == '0 && load_on)
      else $error("outputs not idle after reset");
   wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
      |=> axi_rsp.bvalid) else $error("no write response");
   b_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
      else $error("write response repeated");
   rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("no read response");
   r_done_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read response repeated");
   colour_draw_a: assert property (evt.colour |-> evt.redraw) else $error("colour without redraw");
   english_chord_a: assert property (evt.english |-> evt.up && evt.down && evt.silence)
      else $error("english without chord");
   alarm_rpt_a: assert property ($rose(alarm_in) |-> ##[2:8] evt.alarm_rpt)
      else $error("alarm not reported");
endmodule

bind rti_top rti_props i_rti_props (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
   .alarm_in(alarm_in), .txd(txd), .evt(evt), .load_on(load_on));

// ---- rti_term.sv ----
// Purpose: Terminal model sending 8N1 keystrokes.
// Assumes: Bit time set in aclk cycles.
// Notes:   Line idles high between frames.
module rti_term (
   input wire logic aclk,
   output logic rxd
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Framing
   // ----------------------------------------
   int bit_cyc = 16;
   initial rxd = 1'b1;
   // Start bit, data LSB first, one stop bit
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (bit_cyc) @(posedge aclk);
      end
   endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for rti_top.
// Assumes: Short counts for bit time and timers.
// Notes:   Events are scored through a queue.
module tb_top
   import rti_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Bench state
   // ----------------------------------------
   logic aclk;
   logic aresetn = 0;
   rti_axi_req_t axi_req = '0;
   rti_axi_rsp_t axi_rsp;
   logic rxd, txd, load_on;
   logic alarm_in = 0;
   logic pos4_in = 0;
   logic modem_session = 0;
   rti_evt_t evt;
   int n_errors = 0;
   int check_count = 0;
   logic [14:0] exp_q[$];
   logic [15:0] lfsr = 16'd17310;
   logic [31:0] d;
   logic [1:0] r;
   logic [7:0] k_tab [21] = '{8'h58, KEY_SPACE, KEY_UP, KEY_DOWN, KEY_ENTER, KEY_REDRAW, KEY_CHARSET,
      KEY_COLOUR, KEY_SCRNUM, KEY_SILENCE, KEY_HANGUP, KEY_CHORD_UDS, KEY_CHORD_UD, KEY_CHORD_DS, 8'h51,
      KEY_BINARY, KEY_UP, 8'h45, 8'h58, 8'h49, 8'h54};
   logic [14:0] e_tab [21] = '{15'h0, 15'h8, 15'h1, 15'h2, 15'h4, 15'h20, 15'h40, 15'ha0, 15'h100,
      15'h200, 15'h1000, 15'h2203, 15'h3, 15'h202, 15'h0, 15'h400, 15'h0, 15'h0, 15'h0, 15'h0, 15'h800};

   rti_top #(.BIT_FAST(17'd16), .BIT_SLOW(17'd32), .RELOCK_CNT(36'd50), .RESTORE_CNT(36'd20)) i_rti_top (
      .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .rxd(rxd), .txd(txd),
      .alarm_in(alarm_in), .pos4_in(pos4_in), .modem_session(modem_session), .evt(evt), .load_on(load_on));
   rti_term i_rti_term (.aclk(aclk), .rxd(rxd));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Valids drop once taken; ready stays high, so back-to-back calls never toggle it in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      axi_req.awaddr <= a;
      axi_req.wdata <= v;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (!axi_rsp.bvalid);
   endtask
   task automatic rd(input logic [7:0] a);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (!axi_rsp.rvalid);
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
   endtask
   task automatic key(input logic [7:0] k, input logic [14:0] e);
      if (e != '0) exp_q.push_back(e);
      i_rti_term.send(k);
      repeat (8) @(posedge aclk);
   endtask

   // Any event pulse takes the oldest note; none noted means a stray
   always @(posedge aclk) begin
      if (aresetn && evt !== '0) begin
         if (exp_q.size() == 0) chk(32'(evt), 32'h0);
         else chk(32'(evt), 32'(exp_q.pop_front()));
      end
   end

   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      end_sim();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_STATUS);
      chk(d, 32'h80);
      rd(8'h20);
      chk({d[29:0], r}, {30'h0, RESP_SLVERR});
      wr(OFS_TXDATA, 32'h55);
      repeat (2) @(posedge aclk);
      chk(32'(txd), 32'h0);
      repeat (16) @(posedge aclk);
      chk(32'(txd), 32'h1);
      alarm_in <= 1'b1;
      modem_session <= 1'b1;
      exp_q.push_back(15'h10);
      repeat (12) @(posedge aclk);
      for (int i = 0; i < 21; i++) key(k_tab[i], e_tab[i]);
      rd(OFS_STATUS);
      chk(d, 32'h108d);
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      wr(OFS_PWD_LO, {lfsr, lfsr} | 32'h1);
      rd(OFS_PWD_LO);
      chk(d, {lfsr, lfsr} | 32'h1);
      pos4_in <= 1'b1;
      wr(OFS_CMD, 32'h1);
      exp_q.push_back(15'h4000);
      wr(OFS_CMD, 32'h4);
      rd(OFS_STATUS);
      chk(32'(d[6:5]), 32'h1);
      rd(OFS_EVENTS);
      chk(d, 32'h7fff);
      wr(OFS_EVENTS, 32'h7fff);
      rd(OFS_EVENTS);
      chk(d, 32'h0);
      wr(OFS_CMD, 32'h2);
      rd(OFS_STATUS);
      chk(32'(d[6:5]), 32'h2);
      wr(OFS_CMD, 32'h4);
      chk(32'(load_on), 32'h0);
      wr(OFS_CMD, 32'hc);
      chk(32'(load_on), 32'h0);
      repeat (25) @(posedge aclk);
      chk(32'(load_on), 32'h1);
      repeat (40) @(posedge aclk);
      rd(OFS_STATUS);
      chk(32'(d[6:5]), 32'h1);
      wr(OFS_CMD, 32'h2);
      wr(OFS_PWD_LO, 32'h4141_4141);
      wr(OFS_PWD_HI, 32'h4141);
      wr(OFS_CMD, 32'h1);
      repeat (60) @(posedge aclk);
      rd(OFS_STATUS);
      chk(32'(d[6:5]), 32'h0);
      wr(OFS_CTRL, 32'h1);
      i_rti_term.bit_cyc = 32;
      modem_session <= 1'b0;
      key(KEY_HANGUP, 15'h0);
      key(KEY_SPACE, 15'h8);
      chk(32'(exp_q.size()), 32'h0);
      end_sim();
   end
endmodule
